//--- sss_pkg.sv
`default_nettype none
package sss_pkg;
  // -------------------------------------------------------------
  // Clock, tone and baud timing.
  // -------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned TONE_TIME_MS = 100;
  localparam int unsigned TONE_CYCLES  = CLK_HZ / 1000 * TONE_TIME_MS;
  localparam int unsigned TONE_W       = 25;
  localparam logic [24:0] TONE_ONE     = 25'h0000001;
  localparam int unsigned RATE_2400    = 2400;
  localparam int unsigned RATE_4800    = 4800;
  localparam int unsigned RATE_9600    = 9600;
  localparam int unsigned RATE_19200   = 19200;
  localparam int unsigned DIV_2400     = CLK_HZ / RATE_2400;
  localparam int unsigned DIV_4800     = CLK_HZ / RATE_4800;
  localparam int unsigned DIV_9600     = CLK_HZ / RATE_9600;
  localparam int unsigned DIV_19200    = CLK_HZ / RATE_19200;
  localparam int unsigned BAUD_W       = 17;

  // -------------------------------------------------------------
  // Serial rate select codes.
  // -------------------------------------------------------------
  localparam logic [2:0] RATE_OFF   = 3'h0;
  localparam logic [2:0] RATE_C2400 = 3'h1;
  localparam logic [2:0] RATE_C4800 = 3'h2;
  localparam logic [2:0] RATE_C9600 = 3'h3;
  localparam logic [2:0] RATE_C19K2 = 3'h4;
  localparam logic [7:0] RATE_MAX   = 8'h04;

  // -------------------------------------------------------------
  // Register byte offsets.
  // -------------------------------------------------------------
  localparam logic [7:0] REG_QCOND  = 8'h00;
  localparam logic [7:0] REG_QEVENT = 8'h04;
  localparam logic [7:0] REG_QEN    = 8'h08;
  localparam logic [7:0] REG_ADDR   = 8'h0c;
  localparam logic [7:0] REG_RATE   = 8'h10;
  localparam logic [7:0] REG_ECHO   = 8'h14;
  localparam logic [7:0] REG_PACE   = 8'h18;
  localparam logic [7:0] REG_PROMPT = 8'h1c;
  localparam logic [7:0] REG_CMD    = 8'h20;
  localparam logic [7:0] REG_STAT   = 8'h24;
  localparam int unsigned CMD_TONE  = 0;
  localparam int unsigned CMD_STORE = 1;

  // -------------------------------------------------------------
  // Questionable bit positions, masks and reset value.
  // -------------------------------------------------------------
  localparam int unsigned NCOND       = 7;
  localparam int unsigned QB_VOLT_REG = 0;
  localparam int unsigned QB_CURR_REG = 1;
  localparam int unsigned QB_THERMAL  = 3;
  localparam int unsigned QB_FOLLOWER = 6;
  localparam int unsigned QB_VOLT_ERR = 12;
  localparam int unsigned QB_CURR_ERR = 13;
  localparam int unsigned QB_ABSORB   = 14;
  localparam logic [15:0] Q_USED_MASK  = 16'h704b;
  localparam logic [15:0] Q_LATCH_MASK = 16'h3000;
  localparam logic [15:0] QEN_RST      = 16'h0000;

  // -------------------------------------------------------------
  // Bus address limit and serial characters.
  // -------------------------------------------------------------
  localparam logic [7:0] ADDR_MAX    = 8'h1e;
  localparam logic [7:0] CHAR_LF     = 8'h0a;
  localparam logic [7:0] CHAR_PROMPT = 8'h3e;
endpackage
`default_nettype wire

//--- sss_sync.sv
`default_nettype none
module sss_sync (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic [sss_pkg::NCOND-1:0]   raw_i,
  output logic      [sss_pkg::NCOND-1:0]   level_o
);
  // -------------------------------------------------------------
  // State.
  // -------------------------------------------------------------
  typedef struct packed {
    logic [sss_pkg::NCOND-1:0] s1;
    logic [sss_pkg::NCOND-1:0] s2;
    logic [sss_pkg::NCOND-1:0] s3;
    logic [sss_pkg::NCOND-1:0] lvl;
  } sss_sync_type;

  sss_sync_type                q, n;
  logic [sss_pkg::NCOND-1:0]   agree;

  // A bit changes only once the second and third stages agree.
  for (genvar g = 0; g < sss_pkg::NCOND; g++) begin : g_bit
    assign agree[g] = (q.s2[g] == q.s3[g]) ? q.s3[g] : q.lvl[g];
  end

  // The first stage feeds only the second stage.
  always_comb begin
    n     = q;
    n.s1  = raw_i;
    n.s2  = q.s1;
    n.s3  = q.s2;
    n.lvl = agree;
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign level_o = q.lvl;
endmodule
`default_nettype wire

//--- sss_ques.sv
`default_nettype none
module sss_ques (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [15:0] cond_i,
  input  wire logic [1:0]  en_we_i,
  input  wire logic [15:0] en_data_i,
  input  wire logic        ev_rd_i,
  output logic      [15:0] ev_o,
  output logic      [15:0] en_o,
  output logic             summary_o
);
  // -------------------------------------------------------------
  // State.
  // -------------------------------------------------------------
  typedef struct packed {
    logic [15:0] prev;
    logic [15:0] ev;
    logic [15:0] en;
  } sss_ques_type;

  sss_ques_type q, n;
  logic [15:0]  rise;

  assign rise = cond_i & ~q.prev & sss_pkg::Q_LATCH_MASK;

  // Latch rising edges of latchable bits; a new edge beats the clear.
  always_comb begin
    n      = q;
    n.prev = cond_i;
    if (ev_rd_i) begin
      n.ev = 16'h0000;
    end
    n.ev = n.ev | rise;
    for (int b = 0; b < 2; b++) begin
      if (en_we_i[b]) begin
        n.en[b*8 +: 8] = en_data_i[b*8 +: 8] & sss_pkg::Q_USED_MASK[b*8 +: 8];
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  // Summary is any enabled event bit.
  assign ev_o      = q.ev;
  assign en_o      = q.en;
  assign summary_o = |(q.ev & q.en);

  // -------------------------------------------------------------
  // Checks.
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_unlatched_zero: assert property ((ev_o & ~sss_pkg::Q_LATCH_MASK) == 16'h0000)
    else $error("Unlatched event bit set.");
  chk_rise_latch: assert property (rise[sss_pkg::QB_CURR_ERR] |=> ev_o[sss_pkg::QB_CURR_ERR]
    ##1 (ev_o[sss_pkg::QB_CURR_ERR] || $past(ev_rd_i)))
    else $error("Current error edge not latched.");
  chk_read_clear: assert property (ev_rd_i && rise == 16'h0000 |=> ev_o == 16'h0000)
    else $error("Event read did not clear.");
  chk_enable_store: assert property (en_we_i == 2'h3 |=>
    en_o == ($past(en_data_i) & sss_pkg::Q_USED_MASK))
    else $error("Enable mask not stored.");
endmodule
`default_nettype wire

//--- sss_top.sv
// Implementation choices: the Wishbone register port and the address map.
`default_nettype none
module sss_top #(
  parameter int unsigned TONE_CYCLES = sss_pkg::TONE_CYCLES,
  parameter int unsigned DIV_2400    = sss_pkg::DIV_2400,
  parameter int unsigned DIV_4800    = sss_pkg::DIV_4800,
  parameter int unsigned DIV_9600    = sss_pkg::DIV_9600,
  parameter int unsigned DIV_19200   = sss_pkg::DIV_19200
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  input  wire logic        energy_absorbing_flag_i,
  input  wire logic        current_error_flag_i,
  input  wire logic        voltage_error_flag_i,
  input  wire logic        follower_unit_fault_flag_i,
  input  wire logic        thermal_fault_flag_i,
  input  wire logic        current_regulation_fault_flag_i,
  input  wire logic        voltage_regulation_fault_flag_i,
  output logic             ques_summary_o,
  input  wire logic [4:0]  nv_bus_address_i,
  input  wire logic [2:0]  nv_rate_i,
  input  wire logic        nv_flow_i,
  input  wire logic        nv_prompt_i,
  input  wire logic        nv_echo_i,
  output logic             store_settings_o,
  input  wire logic        inst_reset_i,
  output logic             tone_o,
  output logic      [4:0]  listen_address_o,
  output logic             serial_enable_o,
  output logic             baud_tick_o,
  output logic             flow_control_o,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_char_i,
  input  wire logic        parse_done_i,
  output logic             tx_valid_o,
  output logic      [7:0]  tx_char_o,
  input  wire logic        tx_ready_i
);
  // -------------------------------------------------------------
  // State.
  // -------------------------------------------------------------
  typedef struct packed {
    logic                       ack;
    logic [31:0]                rdata;
    logic [4:0]                 addr;
    logic [2:0]                 rate;
    logic                       echo_act;
    logic                       echo_stop;
    logic                       flow;
    logic                       prompt;
    logic                       prompt_pend;
    logic                       tone;
    logic [sss_pkg::TONE_W-1:0] tone_cnt;
    logic [sss_pkg::BAUD_W-1:0] baud_cnt;
    logic                       tick;
    logic                       tx_valid;
    logic [7:0]                 tx_char;
    logic                       store;
  } sss_top_type;

  sss_top_type                q, n;
  logic [5:0]                 idx;
  logic                       acc;
  logic                       wr;
  logic                       rd;
  logic                       free;
  logic                       echo_ld;
  logic                       ev_rd;
  logic [1:0]                 en_we;
  logic [31:0]                rd_mux;
  logic [sss_pkg::BAUD_W-1:0] div_m1;
  logic [sss_pkg::NCOND-1:0]  raw;
  logic [sss_pkg::NCOND-1:0]  lvl;
  logic [15:0]                cond;
  logic [15:0]                ev;
  logic [15:0]                en;
  logic                       summary;

  // True when the word address selects the given register.
  function automatic logic hit(input logic [7:0] a, input logic [5:0] i);
    return i == a[7:2];
  endfunction

  // -------------------------------------------------------------
  // Bus decode.
  // -------------------------------------------------------------
  // A request is taken once, in the cycle before its acknowledge.
  assign idx     = adr_i[7:2];
  assign acc     = cyc_i & stb_i & ~q.ack;
  assign wr      = acc & we_i;
  assign rd      = acc & ~we_i;
  assign ev_rd   = rd & hit(sss_pkg::REG_QEVENT, idx);
  assign en_we   = sel_i[1:0] & {2{wr & hit(sss_pkg::REG_QEN, idx)}};

  // -------------------------------------------------------------
  // Questionable group.
  // -------------------------------------------------------------
  // Pin conditions, highest bit first, pass a three-stage filter.
  assign raw = {energy_absorbing_flag_i, current_error_flag_i,
                voltage_error_flag_i, follower_unit_fault_flag_i,
                thermal_fault_flag_i, current_regulation_fault_flag_i,
                voltage_regulation_fault_flag_i};

  sss_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .raw_i   (raw),
    .level_o (lvl)
  );

  // Place each filtered level at its bit; unnamed bits stay zero.
  always_comb begin
    cond                       = 16'h0000;
    cond[sss_pkg::QB_ABSORB]   = lvl[6];
    cond[sss_pkg::QB_CURR_ERR] = lvl[5];
    cond[sss_pkg::QB_VOLT_ERR] = lvl[4];
    cond[sss_pkg::QB_FOLLOWER] = lvl[3];
    cond[sss_pkg::QB_THERMAL]  = lvl[2];
    cond[sss_pkg::QB_CURR_REG] = lvl[1];
    cond[sss_pkg::QB_VOLT_REG] = lvl[0];
  end

  sss_ques u_ques (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .cond_i    (cond),
    .en_we_i   (en_we),
    .en_data_i (dat_i[15:0]),
    .ev_rd_i   (ev_rd),
    .ev_o      (ev),
    .en_o      (en),
    .summary_o (summary)
  );

  // -------------------------------------------------------------
  // Read mux and baud divisor.
  // -------------------------------------------------------------
  // Unmapped words read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (idx)
      sss_pkg::REG_QCOND[7:2]:  rd_mux[15:0] = cond;
      sss_pkg::REG_QEVENT[7:2]: rd_mux[15:0] = ev;
      sss_pkg::REG_QEN[7:2]:    rd_mux[15:0] = en;
      sss_pkg::REG_ADDR[7:2]:   rd_mux[4:0]  = q.addr;
      sss_pkg::REG_RATE[7:2]:   rd_mux[2:0]  = q.rate;
      sss_pkg::REG_ECHO[7:2]:   rd_mux[0]    = q.echo_act;
      sss_pkg::REG_PACE[7:2]:   rd_mux[0]    = q.flow;
      sss_pkg::REG_PROMPT[7:2]: rd_mux[0]    = q.prompt;
      sss_pkg::REG_CMD[7:2]:    rd_mux[0]    = q.tone;
      sss_pkg::REG_STAT[7:2]:   rd_mux[2:0]  = {q.echo_stop, q.tone, summary};
      default:                  rd_mux       = 32'h0000_0000;
    endcase
  end

  // Divisor minus one for the selected rate.
  always_comb begin
    unique case (q.rate)
      sss_pkg::RATE_C2400: div_m1 = sss_pkg::BAUD_W'(DIV_2400 - 1);
      sss_pkg::RATE_C4800: div_m1 = sss_pkg::BAUD_W'(DIV_4800 - 1);
      sss_pkg::RATE_C9600: div_m1 = sss_pkg::BAUD_W'(DIV_9600 - 1);
      sss_pkg::RATE_C19K2: div_m1 = sss_pkg::BAUD_W'(DIV_19200 - 1);
      default:             div_m1 = '1;
    endcase
  end

  // -------------------------------------------------------------
  // Next state.
  // -------------------------------------------------------------
  assign free    = ~q.tx_valid | tx_ready_i;
  assign echo_ld = rx_valid_i & q.echo_act & free;

  always_comb begin
    n       = q;
    n.ack   = acc;
    n.store = 1'b0;
    n.tick  = 1'b0;
    if (acc) begin
      n.rdata = rd_mux;
    end
    // Baud tick generator; stopped while the port is off.
    if (q.rate == sss_pkg::RATE_OFF) begin
      n.baud_cnt = '0;
    end else if (q.baud_cnt >= div_m1) begin
      n.baud_cnt = '0;
      n.tick     = 1'b1;
    end else begin
      n.baud_cnt = q.baud_cnt + 1'b1;
    end
    // Tone interval countdown.
    if (q.tone) begin
      n.tone_cnt = q.tone_cnt - 1'b1;
      if (q.tone_cnt == sss_pkg::TONE_ONE) begin
        n.tone = 1'b0;
      end
    end
    // Transmit holding register; echo first, then prompt.
    if (q.tx_valid & tx_ready_i) begin
      n.tx_valid = 1'b0;
    end
    if (echo_ld) begin
      n.tx_valid = 1'b1;
      n.tx_char  = rx_char_i;
    end
    if (rx_valid_i & q.echo_stop & (rx_char_i == sss_pkg::CHAR_LF)) begin
      n.echo_act  = 1'b0;
      n.echo_stop = 1'b0;
    end
    if (q.prompt_pend & free & ~echo_ld) begin
      n.tx_valid    = 1'b1;
      n.tx_char     = sss_pkg::CHAR_PROMPT;
      n.prompt_pend = 1'b0;
    end
    if (parse_done_i & q.prompt) begin
      n.prompt_pend = 1'b1;
    end
    // Instrument reset ends tone and a pending prompt but keeps echo.
    if (inst_reset_i) begin
      n.tone        = 1'b0;
      n.tone_cnt    = '0;
      n.prompt_pend = 1'b0;
    end
    // Register writes; all settings but the enable mask sit in byte lane 0.
    if (wr & sel_i[0]) begin
      if (hit(sss_pkg::REG_ADDR, idx) && dat_i[7:0] <= sss_pkg::ADDR_MAX) begin
        n.addr = dat_i[4:0];
      end
      if (hit(sss_pkg::REG_RATE, idx) && dat_i[7:0] <= sss_pkg::RATE_MAX) begin
        n.rate = dat_i[2:0];
      end
      if (hit(sss_pkg::REG_ECHO, idx)) begin
        if (dat_i[0]) begin
          n.echo_act  = 1'b1;
          n.echo_stop = 1'b0;
        end else begin
          n.echo_stop = n.echo_act;
        end
      end
      if (hit(sss_pkg::REG_PACE, idx)) begin
        n.flow = dat_i[0];
      end
      if (hit(sss_pkg::REG_PROMPT, idx)) begin
        n.prompt = dat_i[0];
      end
      if (hit(sss_pkg::REG_CMD, idx)) begin
        if (dat_i[sss_pkg::CMD_TONE]) begin
          n.tone     = 1'b1;
          n.tone_cnt = sss_pkg::TONE_W'(TONE_CYCLES);
        end
        n.store = dat_i[sss_pkg::CMD_STORE];
      end
    end
    // Reset restores the stored settings, clamped to legal values.
    if (rst_i) begin
      n        = '0;
      n.addr   = (nv_bus_address_i <= sss_pkg::ADDR_MAX[4:0]) ? nv_bus_address_i : 5'h00;
      n.rate   = (nv_rate_i <= sss_pkg::RATE_MAX[2:0]) ? nv_rate_i : sss_pkg::RATE_OFF;
      n.flow   = nv_flow_i;
      n.prompt = nv_prompt_i;
      n.echo_act = nv_echo_i;
    end
  end

  // State register.
  always_ff @(posedge clk_i) begin
    q <= n;
  end

  // -------------------------------------------------------------
  // Outputs.
  // -------------------------------------------------------------
  assign ack_o            = q.ack;
  assign dat_o            = q.rdata;
  assign ques_summary_o   = summary;
  assign store_settings_o = q.store;
  assign tone_o           = q.tone;
  assign listen_address_o = q.addr;
  assign serial_enable_o  = q.rate != sss_pkg::RATE_OFF;
  assign baud_tick_o      = q.tick;
  assign flow_control_o   = q.flow;
  assign tx_valid_o       = q.tx_valid;
  assign tx_char_o        = q.tx_char;

  // -------------------------------------------------------------
  // Checks.
  // -------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_single: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("Acknowledge not a single cycle.");
  chk_addr_write: assert property (wr && sel_i[0] && hit(sss_pkg::REG_ADDR, idx)
    && dat_i[7:0] <= sss_pkg::ADDR_MAX |=> listen_address_o == $past(dat_i[4:0]))
    else $error("Bus address write not adopted.");
  chk_addr_range: assert property (listen_address_o <= sss_pkg::ADDR_MAX[4:0])
    else $error("Bus address out of range.");
  chk_rate_read: assert property (rd && hit(sss_pkg::REG_RATE, idx) |=>
    dat_o == {29'h0000_0000, $past(q.rate)})
    else $error("Rate read mismatch.");
  chk_baud_off: assert property (!serial_enable_o |=> !baud_tick_o)
    else $error("Baud tick while port off.");
  chk_tone_start: assert property (wr && sel_i[0] && hit(sss_pkg::REG_CMD, idx)
    && dat_i[sss_pkg::CMD_TONE] |=> tone_o [*2])
    else $error("Tone not started.");
  chk_tone_end: assert property ($fell(tone_o) && !$past(inst_reset_i) |->
    $past(q.tone_cnt) == sss_pkg::TONE_ONE)
    else $error("Tone ended early.");
  chk_echo_back: assert property (echo_ld |=>
    tx_valid_o && tx_char_o == $past(rx_char_i))
    else $error("Received character not echoed.");
  chk_echo_stop: assert property (rx_valid_i && q.echo_stop && rx_char_i == sss_pkg::CHAR_LF
    && !wr |=> !q.echo_act)
    else $error("Echo did not stop at line feed.");
  chk_echo_kept: assert property (inst_reset_i && !wr && !rx_valid_i |=>
    $stable(q.echo_act))
    else $error("Instrument reset changed echo.");
  chk_prompt_sent: assert property (parse_done_i && q.prompt && !inst_reset_i |=>
    q.prompt_pend || (tx_valid_o && tx_char_o == sss_pkg::CHAR_PROMPT))
    else $error("Prompt not queued.");

  cov_echo_stop: cover property (q.echo_stop ##1 !q.echo_act);
  cov_prompt:    cover property (tx_valid_o && tx_char_o == sss_pkg::CHAR_PROMPT);
  cov_ev_clear:  cover property (ev_rd && ev != 16'h0000);
  cov_summary:   cover property ($rose(ques_summary_o));
endmodule
`default_nettype wire

//--- sss_host_energy_absorbing_flag.sv
`default_nettype none
// Serial character energy_absorbing_flag standing in for the host; when slow it is ready every other cycle.
module sss_host_energy_absorbing_flag (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       slow_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_char_i,
  output logic            tx_ready_o,
  output logic [7:0]      last_o,
  output logic [7:0]      count_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Takes one character at each edge where valid and ready meet.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_ready_o <= 1'b0;
      last_o     <= 8'h00;
      count_o    <= 8'h00;
    end else begin
      tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
      if (tx_valid_i && tx_ready_o) begin
        last_o  <= tx_char_i;
        count_o <= count_o + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

//--- sss_top_tb.sv
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module sss_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 0, rst_i = 1, we = 0, cyc = 0, stb = 0, rxv = 0, prs = 0, irst = 0, ack;
  logic [7:0]  adr = 0, rxc = 0, last, cnt, txc;
  logic [31:0] dat = 0, dout, q;
  logic [6:0]  cf = 0;
  logic        summ, tone, sen, flow, txv, txr;
  logic [4:0]  la;
  logic [4:0]  nva = 5'h05;
  logic [2:0]  nvr = 3'h3;
  logic [3:0]  sel = 4'h0, bsel = 4'h3;
  logic        nvf = 1, nvp = 1, nve = 1, slow = 1, store, baud;
  int          n_fail = 0, checks_done = 0, n;
  // Clock at 200 MHz.
  always #2.5 clk_i = ~clk_i;
  sss_top #(.TONE_CYCLES(10), .DIV_2400(8), .DIV_4800(6), .DIV_9600(4), .DIV_19200(3)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat), .dat_o(dout), .we_i(we),
    .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .energy_absorbing_flag_i(cf[6]),
    .current_error_flag_i(cf[5]), .voltage_error_flag_i(cf[4]),
    .follower_unit_fault_flag_i(cf[3]), .thermal_fault_flag_i(cf[2]),
    .current_regulation_fault_flag_i(cf[1]), .voltage_regulation_fault_flag_i(cf[0]),
    .ques_summary_o(summ), .nv_bus_address_i(nva), .nv_rate_i(nvr), .nv_flow_i(nvf),
    .nv_prompt_i(nvp), .nv_echo_i(nve), .store_settings_o(store), .inst_reset_i(irst),
    .tone_o(tone), .listen_address_o(la), .serial_enable_o(sen), .baud_tick_o(baud),
    .flow_control_o(flow), .rx_valid_i(rxv), .rx_char_i(rxc), .parse_done_i(prs),
    .tx_valid_o(txv), .tx_char_o(txc), .tx_ready_i(txr));
  sss_host_energy_absorbing_flag host (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .tx_valid_i(txv),
    .tx_char_i(txc), .tx_ready_o(txr), .last_o(last), .count_o(cnt));
  // One classic Wishbone cycle, held until ack is sampled high.
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    sel <= bsel;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dout;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
    wb(a, 1'b0, 32'h0);
    `CHK(s, e, q)
  endtask
  // Sends one received character, then leaves room for the echo to drain.
  task automatic rx(input logic [7:0] c);
    @(posedge clk_i);
    rxv <= 1; rxc <= c;
    @(posedge clk_i);
    rxv <= 0;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog against a hung handshake.
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    end_of_test();
  end
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    rd(sss_pkg::REG_QEN, 32'h0, "qen_rst");
    rd(sss_pkg::REG_ADDR, 32'h5, "addr_rst");
    wb(sss_pkg::REG_ADDR, 1, 32'h1e);
    wb(sss_pkg::REG_ADDR, 1, 32'h1f);
    rd(sss_pkg::REG_ADDR, 32'h1e, "addr");
    `CHK("listen", 5'h1e, la)
    for (int r = 0; r < 6; r++) begin
      wb(sss_pkg::REG_RATE, 1, r);
      rd(sss_pkg::REG_RATE, (r > 4) ? 4 : r, "rate");
      `CHK("ser_en", r != 0, sen)
    end
    // The last legal rate code stays in use; its divisor is 3 in simulation.
    n = 0;
    repeat (30) @(posedge clk_i) n += int'(baud === 1'b1);
    `CHK("ticks", 10, n)
    wb(sss_pkg::REG_QEN, 1, 32'hffff);
    rd(sss_pkg::REG_QEN, 32'h704b, "qen_used");
    wb(sss_pkg::REG_QEN, 1, 32'h3000);
    rd(sss_pkg::REG_QEN, 32'h3000, "qen");
    // Only byte lane 1 enabled: the mask high byte changes, the address does not.
    bsel = 4'h2;
    wb(sss_pkg::REG_QEN, 1, 32'hffff);
    wb(sss_pkg::REG_ADDR, 1, 32'h03);
    bsel = 4'h3;
    rd(sss_pkg::REG_QEN, 32'h7000, "qen_lane");
    rd(sss_pkg::REG_ADDR, 32'h1e, "addr_lane");
    cf <= 7'h20;
    repeat (8) @(posedge clk_i);
    rd(sss_pkg::REG_QCOND, 32'h2000, "cond");
    `CHK("summary", 1'b1, summ)
    rd(sss_pkg::REG_QEVENT, 32'h2000, "event");
    rd(sss_pkg::REG_QEVENT, 32'h0, "ev_clr");
    `CHK("summ_clr", 1'b0, summ)
    cf <= 7'h03;
    repeat (8) @(posedge clk_i);
    rd(sss_pkg::REG_QCOND, 32'h3, "settle");
    rd(sss_pkg::REG_QEVENT, 32'h0, "no_latch");
    wb(sss_pkg::REG_ECHO, 1, 32'h1);
    rd(sss_pkg::REG_ECHO, 32'h1, "echo_on");
    rx(8'h41);
    `CHK("echo", 8'h41, last)
    wb(sss_pkg::REG_ECHO, 1, 32'h0);
    rx(8'h0a);
    rx(8'h43);
    `CHK("echo_stop", 8'h02, cnt)
    rd(sss_pkg::REG_ECHO, 32'h0, "echo_off");
    wb(sss_pkg::REG_ECHO, 1, 32'h1);
    @(posedge clk_i) irst <= 1;
    @(posedge clk_i) irst <= 0;
    rd(sss_pkg::REG_ECHO, 32'h1, "echo_keep");
    wb(sss_pkg::REG_PACE, 1, 32'h1);
    rd(sss_pkg::REG_PACE, 32'h1, "pace");
    `CHK("flow", 1'b1, flow)
    wb(sss_pkg::REG_PROMPT, 1, 32'h1);
    rd(sss_pkg::REG_PROMPT, 32'h1, "prompt");
    slow <= 1'b0;
    @(posedge clk_i) prs <= 1;
    @(posedge clk_i) prs <= 0;
    repeat (8) @(posedge clk_i);
    `CHK("prompt_ch", 8'h3e, last)
    wb(sss_pkg::REG_CMD, 1, 32'h1);
    n = int'(tone === 1'b1);
    repeat (30) @(posedge clk_i) n += int'(tone === 1'b1);
    `CHK("tone_len", 10, n)
    wb(sss_pkg::REG_CMD, 1, 32'h2);
    `CHK("store", 1'b1, store)
    @(posedge clk_i);
    `CHK("store_end", 1'b0, store)
    // Mid-run reset reloads the stored settings, clamping illegal ones.
    nva <= 5'h1f;
    nvr <= 3'h6;
    nvf <= 1'b0;
    nvp <= 1'b0;
    nve <= 1'b0;
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    rd(sss_pkg::REG_ADDR, 32'h0, "addr_clamp");
    rd(sss_pkg::REG_RATE, 32'h0, "rate_clamp");
    `CHK("nv_flow", 1'b0, flow)
    `CHK("nv_ser_en", 1'b0, sen)
    rd(sss_pkg::REG_ECHO, 32'h0, "nv_echo");
    rd(sss_pkg::REG_PROMPT, 32'h0, "nv_prompt");
    end_of_test();
  end
endmodule
`default_nettype wire
